// *** tb_vpw_frame_crc_engine.sv ***
`timescale 1ns/1ps
module tb_vpw_frame_crc_engine;
  import vpw_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic rx_i;
  logic tx_o;
  logic [31:0] rd;
  logic er;
  logic [7:0] q[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  // Short symbol set; keeps MIN<SHORT<BIT<LONG<SYM<SOF, EOD<EOF<IFS and BRK>SOF
  localparam logic [15:0] T_SHORT = 16'h0010;
  localparam logic [15:0] T_LONG = 16'h0020;
  localparam logic [15:0] T_MIN = 16'h0008;
  localparam logic [15:0] T_BIT = 16'h0018;
  localparam logic [15:0] T_SYM = 16'h0029;
  localparam logic [15:0] T_SOF = 16'h0032;
  localparam logic [15:0] T_EOD = 16'h0032;
  localparam logic [15:0] T_EOF = 16'h0046;
  localparam logic [15:0] T_IFS = 16'h004B;
  localparam logic [15:0] T_BRK = 16'h003C;
  vpw_frame_crc_engine #(.SOF_CYC(T_SOF), .EOD_CYC(T_EOD), .EOF_CYC(T_EOF),
    .IFS_CYC(T_IFS), .SHORT_CYC(T_SHORT), .LONG_CYC(T_LONG), .BRK_CYC(T_BRK),
    .MIN_CYC(T_MIN), .BIT_CYC(T_BIT), .SYM_CYC(T_SYM)) u_vpw_frame_crc_engine (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
    .tx_o(tx_o));
  vpw_bus u_vpw_bus (.core_clk_i(core_clk_i), .tx_i(tx_o), .rx_o(rx_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask
  // Idle cycle after release keeps back-to-back calls glitch free
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic busy_wait();
    do apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0); while (rd[ST_TX_BUSY] !== 1'b0);
  endtask
  function automatic logic [7:0] crc_of(input logic [7:0] d[$]);
    logic [7:0] r;
    r = 8'hFF;
    foreach (d[i])
      for (int k = 7; k >= 0; k--)
        r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i][k]) ? 8'h1D : 8'h00);
    return ~r;
  endfunction
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(4);
    reset_n_i <= 1'b1;
    tick(1);
    apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0);
    chk(rd === 32'h0, "status after reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    tick(80);
    apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h1);
    apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0);
    chk(rd[ST_IDLE] === 1'b1, "idle bus");
    chk(rd[ST_TX_BUSY] === 1'b0 && tx_o === 1'b0, "start with empty buffer");
    for (int i = 0; i < 13; i++) apb(1'b1, TX_DATA_OFS, 32'(i));
    apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0);
    chk(rd[15:12] === 4'hC, "buffer limit");
    apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h4);
    q = {8'h5A, 8'h81, 8'h00};
    foreach (q[i]) apb(1'b1, TX_DATA_OFS, {24'h0, q[i]});
    apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h1);
    q.push_back(crc_of(q));
    busy_wait();
    chk(rd[ST_EOF] === 1'b0 && rd[2:0] === 3'h0, "no flag at end of data");
    chk(u_vpw_bus.got.size() == 4 && u_vpw_bus.bad == 0, "tx framing");
    chk(u_vpw_bus.sof_len == T_SOF, "tx start length");
    foreach (q[i]) chk(u_vpw_bus.got[i] === q[i], "tx byte");
    tick(30);
    apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0);
    chk(rd[ST_EOF] === 1'b1 && rd[ST_CRC_ERR] === 1'b0, "end of frame");
    chk(rd[11:8] === 4'h4, "rx count");
    apb(1'b0, RX_DATA_OFS, 32'h0);
    chk(rd[7:0] === q[3], "rx last byte");
    apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h4);
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, STATUS_VECTOR_REGISTER_OFS, 32'h1F);
      q = {8'h12, 8'h34};
      q.push_back(crc_of(q) ^ 8'(b));
      u_vpw_bus.send(q, 1);
      tick(70);
      apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0);
      chk(rd[ST_CRC_ERR] === 1'(b) && rd[11:8] === 4'h3, "rx checksum");
      chk(rd[ST_RX_BYTE] === 1'b1 && rd[ST_IN_FRAME] === 1'b0, "rx byte and frame close");
    end
    apb(1'b1, STATUS_VECTOR_REGISTER_OFS, 32'h1F);
    apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h2);
    apb(1'b0, LINK_CONTROL_TWO_OFS, 32'h0);
    chk(rd[CTL_FAST_BIT] === 1'b1, "fast enable set");
    q = {8'hA7};
    u_vpw_bus.send(q, 4);
    u_vpw_bus.drive(1'b1, 20);
    u_vpw_bus.drive(1'b0, 5);
    apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0);
    chk(rd[ST_INV_SYM] === 1'b1, "break in frame");
    apb(1'b0, LINK_CONTROL_TWO_OFS, 32'h0);
    chk(rd[CTL_FAST_BIT] === 1'b0, "fast enable cleared");
    apb(1'b1, STATUS_VECTOR_REGISTER_OFS, 32'h1F);
    tick(80);
    apb(1'b1, TX_DATA_OFS, 32'h96);
    apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h1);
    n = 0;
    while (tx_o !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk(tx_o === 1'b1, "start on idle bus");
    u_vpw_bus.drive(1'b1, 65);
    chk(tx_o === 1'b0, "tx stops on break");
    u_vpw_bus.drive(1'b0, 2);
    apb(1'b0, STATUS_VECTOR_REGISTER_OFS, 32'h0);
    chk(rd[ST_TX_ERR] === 1'b1, "tx error flag");
    apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h4);
    apb(1'b1, STATUS_VECTOR_REGISTER_OFS, 32'h1F);
    tick(80);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, TX_DATA_OFS, 32'h3C);
      q = {8'h11};
      fork
        u_vpw_bus.send(q, 1);
        begin
          tick(10);
          apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h1);
        end
      join
      if (m == 1) begin
        u_vpw_bus.drive(1'b0, 55);
        u_vpw_bus.drive(1'b1, 1);
        u_vpw_bus.drive(1'b0, 0);
      end
      n = 0;
      while (tx_o !== 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
      chk(m ? n <= 3 : (n >= 57 && n <= 63), "start after separation");
      busy_wait();
      apb(1'b1, LINK_CONTROL_TWO_OFS, 32'h4);
      tick(80);
    end
    chk(u_vpw_bus.tx_max < T_BRK, "no break sent");
    print_verdict();
  end
endmodule

// *** vpw_bus.sv ***
`timescale 1ns/1ps
module vpw_bus (
  input wire logic core_clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  logic drv = 1'b0;
  logic lvl = 1'b0;
  logic [7:0] sh = 8'h00;
  int run = 0;
  int nbit = 0;
  int bad = 0;
  int sof_len = 0;
  int tx_run = 0;
  int tx_max = 0;
  logic [7:0] got[$];
  // Wired-OR: any active driver dominates the passive pull
  assign rx_o = tx_i | drv;
  // ---------------------------------------------------------------
  // Frame decoder
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    tx_run = tx_i ? tx_run + 1 : 0;
    if (tx_run > tx_max) tx_max = tx_run;
    if (rx_o === lvl) run = run + 1;
    else begin
      if (lvl && run > 40) begin
        sof_len = run;
        // Errors count per frame; unknowns seen before reset are not framing faults
        bad = 0;
        nbit = 0;
        got.delete();
      end else if (run <= 40) begin
        if (run != 16 && run != 32) bad++;
        if (nbit % 8 == 0 && lvl) bad++;
        sh = {sh[6:0], lvl ^ (run >= 24)};
        nbit++;
        if (nbit % 8 == 0) got.push_back(sh);
      end
      lvl = rx_o;
      run = 1;
    end
  end
  task automatic drive(input logic l, input int n);
    drv <= l;
    repeat (n) @(posedge core_clk_i);
  endtask
  // Lengths divided by dv for fast-mode traffic; ends inside a passive bit
  task automatic send(input logic [7:0] d[$], input int dv);
    drive(1'b1, 50 / dv);
    foreach (d[i])
      for (int k = 7; k >= 0; k--)
        drive(k % 2 == 0, ((d[i][k] ^ (k % 2 == 0)) ? 32 : 16) / dv);
    drive(1'b0, 16 / dv);
  endtask
endmodule

// *** vpw_frame_crc_engine.sv ***
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module vpw_frame_crc_engine #(
  parameter logic [15:0] SOF_CYC = 16'(vpw_pkg::SOF_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] EOD_CYC = 16'(vpw_pkg::EOD_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] EOF_CYC = 16'(vpw_pkg::EOF_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] IFS_CYC = 16'(vpw_pkg::IFS_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] SHORT_CYC = 16'(vpw_pkg::SHORT_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] LONG_CYC = 16'(vpw_pkg::LONG_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] BRK_CYC = 16'(vpw_pkg::BRK_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] MIN_CYC = 16'(vpw_pkg::MIN_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] BIT_CYC = 16'(vpw_pkg::BIT_US * vpw_pkg::CLK_MHZ),
  parameter logic [15:0] SYM_CYC = 16'(vpw_pkg::SYM_US * vpw_pkg::CLK_MHZ)
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_i,
  output logic tx_o
);
  import vpw_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  // Fast receive runs four times quicker, so decision points shrink by four
  function automatic logic [15:0] sc(input logic [15:0] v, input logic f);
    sc = f ? {2'b00, v[15:2]} : v;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [7:0] txbuf_q [0:11];
  logic [3:0] tx_len_q;
  logic fast_q;
  logic f_crc_q, f_inv_q, f_eof_q, f_rxb_q, f_txe_q;
  logic rx_q, brk_q, in_frame_q, got_frame_q;
  logic [15:0] per_q;
  logic [7:0] rx_crc_q, rx_sh_q, rx_data_q;
  logic [2:0] rx_bc_q;
  logic [3:0] rx_cnt_q;
  tx_state_t tx_st_q;
  logic tx_o_q, tx_ph_q;
  logic [15:0] tx_cnt_q, tx_dur_q, tx_act_q;
  logic [3:0] tx_idx_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_crc_q;
  logic access, wr, hit, tx_go, tx_busy, tx_brk, start_ok, bus_idle;
  logic rx_rise, rx_fall, rx_sof, rx_bit_v, rx_bit, rx_bad, rx_ovf;
  logic frame_end, eof_pulse, brk_pulse, byte_done;
  logic nx_ph, nx_val, nx_lvl, tx_last, bit_end, tx_cur_val;
  logic [2:0] nx_bit;
  logic [3:0] nx_idx;
  logic [7:0] nx_byte, cur_byte;
  logic [15:0] nx_dur;
  logic [31:0] rmux;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  assign access = psel_i && penable_i;
  assign wr = access && pwrite_i;
  assign hit = (paddr_i == LINK_CONTROL_TWO_OFS) || (paddr_i == TX_DATA_OFS) ||
               (paddr_i == STATUS_VECTOR_REGISTER_OFS) || (paddr_i == RX_DATA_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = access && !hit;
  assign prdata_o = rdata_q;

  always_comb begin
    rmux = 32'h0000_0000;
    case (paddr_i)
      LINK_CONTROL_TWO_OFS: rmux[CTL_FAST_BIT] = fast_q;
      STATUS_VECTOR_REGISTER_OFS: begin
        rmux[ST_CRC_ERR] = f_crc_q;
        rmux[ST_INV_SYM] = f_inv_q;
        rmux[ST_EOF] = f_eof_q;
        rmux[ST_RX_BYTE] = f_rxb_q;
        rmux[ST_TX_ERR] = f_txe_q;
        rmux[ST_TX_BUSY] = tx_busy || (tx_st_q == TX_WAIT);
        rmux[ST_IDLE] = bus_idle;
        rmux[ST_IN_FRAME] = in_frame_q;
        rmux[ST_RX_CNT_LO +: 4] = rx_cnt_q;
        rmux[ST_TX_LEN_LO +: 4] = tx_len_q;
      end
      RX_DATA_OFS: rmux[7:0] = rx_data_q;
      default: rmux = 32'h0000_0000;
    endcase
  end

  // Read data sampled in setup so prdata comes straight from a flop
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i) begin
      rdata_q <= rmux;
    end
  end

  // ---------------------------------------------------------------
  // Control and transmit buffer
  // ---------------------------------------------------------------
  // Start ignored with an empty buffer or while a frame is pending
  assign tx_go = wr && (paddr_i == LINK_CONTROL_TWO_OFS) && pwdata_i[CTL_GO_BIT] &&
                 (tx_st_q == TX_IDLE) && (tx_len_q != 4'h0);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_len_q <= 4'h0;
      for (int i = 0; i < 12; i++) begin
        txbuf_q[i] <= 8'h00;
      end
    end else if (tx_st_q == TX_IDLE && !tx_go) begin
      if (wr && paddr_i == TX_DATA_OFS && tx_len_q < MAX_BYTES) begin
        txbuf_q[tx_len_q] <= pwdata_i[7:0];
        tx_len_q <= 4'(tx_len_q + 4'h1);
      end else if (wr && paddr_i == LINK_CONTROL_TWO_OFS && pwdata_i[CTL_FLUSH_BIT]) begin
        tx_len_q <= 4'h0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fast_q <= 1'b0;
    end else if (brk_pulse && in_frame_q) begin
      fast_q <= 1'b0;
    end else if (wr && paddr_i == LINK_CONTROL_TWO_OFS) begin
      fast_q <= pwdata_i[CTL_FAST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Receive symbol timing and decode
  // ---------------------------------------------------------------
  assign rx_rise = rx_i && !rx_q;
  assign rx_fall = !rx_i && rx_q;
  assign bus_idle = !rx_i && per_q >= IFS_CYC;
  assign brk_pulse = rx_i && per_q == sc(BRK_CYC, fast_q);
  assign frame_end = in_frame_q && !rx_i && per_q == sc(EOD_CYC, fast_q);
  assign eof_pulse = got_frame_q && !rx_i && per_q == sc(EOF_CYC, fast_q);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_q <= 1'b0;
      per_q <= 16'h0000;
      brk_q <= 1'b0;
    end else begin
      rx_q <= rx_i;
      if (rx_rise || rx_fall) begin
        per_q <= 16'h0000;
      end else if (per_q != PER_MAX) begin
        per_q <= 16'(per_q + 16'h0001);
      end
      if (brk_pulse) begin
        brk_q <= 1'b1;
      end else if (rx_fall) begin
        brk_q <= 1'b0;
      end
    end
  end

  // Passive then active bits decode by length at the closing edge
  always_comb begin
    rx_sof = 1'b0;
    rx_bit_v = 1'b0;
    rx_bit = 1'b0;
    rx_bad = 1'b0;
    if (rx_fall && !brk_q) begin
      if (per_q >= sc(SYM_CYC, fast_q)) begin
        rx_sof = 1'b1;
      end else if (in_frame_q) begin
        rx_bad = per_q < sc(MIN_CYC, fast_q);
        rx_bit_v = !rx_bad;
        rx_bit = per_q < sc(BIT_CYC, fast_q);
      end
    end else if (rx_rise && in_frame_q) begin
      rx_bad = per_q < sc(MIN_CYC, fast_q);
      rx_bit_v = !rx_bad;
      rx_bit = per_q >= sc(BIT_CYC, fast_q);
    end
  end

  assign byte_done = rx_bit_v && rx_bc_q == 3'd7;
  assign rx_ovf = byte_done && rx_cnt_q == MAX_BYTES;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      in_frame_q <= 1'b0;
      got_frame_q <= 1'b0;
      rx_crc_q <= CRC_INIT;
      rx_sh_q <= 8'h00;
      rx_bc_q <= 3'd0;
      rx_cnt_q <= 4'h0;
      rx_data_q <= 8'h00;
    end else if (brk_pulse) begin
      in_frame_q <= 1'b0;
      got_frame_q <= 1'b0;
    end else if (rx_sof) begin
      in_frame_q <= 1'b1;
      got_frame_q <= 1'b0;
      rx_crc_q <= CRC_INIT;
      rx_bc_q <= 3'd0;
      rx_cnt_q <= 4'h0;
    end else if (rx_bad || rx_ovf) begin
      in_frame_q <= 1'b0;
    end else if (rx_bit_v) begin
      rx_crc_q <= crc_step(rx_crc_q, rx_bit);
      rx_sh_q <= {rx_sh_q[6:0], rx_bit};
      rx_bc_q <= 3'(rx_bc_q + 3'd1);
      if (byte_done) begin
        rx_data_q <= {rx_sh_q[6:0], rx_bit};
        rx_cnt_q <= 4'(rx_cnt_q + 4'h1);
      end
    end else if (frame_end) begin
      in_frame_q <= 1'b0;
      got_frame_q <= rx_bc_q == 3'd0 && rx_cnt_q != 4'h0;
    end else if (eof_pulse) begin
      got_frame_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status flags, write one to clear; a new event beats the clear
  // ---------------------------------------------------------------
  logic [4:0] clr, set;
  assign clr = (wr && paddr_i == STATUS_VECTOR_REGISTER_OFS) ? pwdata_i[4:0] : 5'h00;
  assign set[ST_CRC_ERR] = frame_end && rx_bc_q == 3'd0 && rx_crc_q != CRC_GOOD;
  assign set[ST_INV_SYM] = rx_bad || rx_ovf || (brk_pulse && in_frame_q) ||
                           (frame_end && rx_bc_q != 3'd0);
  assign set[ST_EOF] = eof_pulse;
  assign set[ST_RX_BYTE] = byte_done && !rx_ovf && !brk_pulse && !rx_sof;
  assign set[ST_TX_ERR] = tx_brk;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      {f_txe_q, f_rxb_q, f_eof_q, f_inv_q, f_crc_q} <= 5'h00;
    end else begin
      {f_txe_q, f_rxb_q, f_eof_q, f_inv_q, f_crc_q} <=
        set | ({f_txe_q, f_rxb_q, f_eof_q, f_inv_q, f_crc_q} & ~clr);
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  assign tx_busy = tx_st_q == TX_SOF || tx_st_q == TX_BIT || tx_st_q == TX_EOD;
  assign tx_brk = brk_pulse && tx_busy;
  // Joining a start seen after end-of-frame keeps nodes aligned
  assign start_ok = bus_idle || (rx_rise && per_q >= EOF_CYC);
  assign bit_end = tx_cnt_q == 16'(tx_dur_q - 16'h0001);
  assign tx_last = tx_bit_q == 3'd0 && tx_ph_q;
  assign cur_byte = tx_ph_q ? ~tx_crc_q : txbuf_q[tx_idx_q];
  assign tx_cur_val = cur_byte[tx_bit_q];

  always_comb begin
    nx_bit = 3'd7;
    nx_idx = 4'h0;
    nx_ph = 1'b0;
    if (tx_st_q == TX_BIT) begin
      nx_idx = tx_idx_q;
      nx_ph = tx_ph_q;
      if (tx_bit_q != 3'd0) begin
        nx_bit = 3'(tx_bit_q - 3'd1);
      end else if (!tx_ph_q && 4'(tx_idx_q + 4'h1) < tx_len_q) begin
        nx_idx = 4'(tx_idx_q + 4'h1);
      end else begin
        nx_ph = 1'b1;
      end
    end
    nx_byte = nx_ph ? ~tx_crc_q : txbuf_q[nx_idx];
    nx_val = nx_byte[nx_bit];
    nx_lvl = (tx_st_q == TX_SOF) ? 1'b0 : !tx_o_q;
    nx_dur = (nx_val ^ nx_lvl) ? LONG_CYC : SHORT_CYC;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_st_q <= TX_IDLE;
      tx_o_q <= 1'b0;
      tx_ph_q <= 1'b0;
      tx_cnt_q <= 16'h0000;
      tx_dur_q <= SHORT_CYC;
      tx_idx_q <= 4'h0;
      tx_bit_q <= 3'd7;
      tx_crc_q <= CRC_INIT;
    end else if (tx_brk) begin
      tx_st_q <= TX_IDLE;
      tx_o_q <= 1'b0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_go) begin
            tx_st_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (start_ok) begin
            tx_st_q <= TX_SOF;
            tx_o_q <= 1'b1;
            tx_cnt_q <= 16'h0000;
            tx_idx_q <= 4'h0;
            tx_bit_q <= 3'd7;
            tx_ph_q <= 1'b0;
            tx_crc_q <= CRC_INIT;
          end
        end
        TX_SOF, TX_BIT: begin
          if (tx_st_q == TX_BIT && bit_end && tx_last) begin
            tx_st_q <= TX_EOD;
            tx_o_q <= 1'b0;
            tx_cnt_q <= 16'h0000;
          end else if ((tx_st_q == TX_SOF && tx_cnt_q == 16'(SOF_CYC - 16'h0001)) ||
                       (tx_st_q == TX_BIT && bit_end)) begin
            tx_st_q <= TX_BIT;
            tx_o_q <= nx_lvl;
            tx_dur_q <= nx_dur;
            tx_bit_q <= nx_bit;
            tx_idx_q <= nx_idx;
            tx_ph_q <= nx_ph;
            tx_cnt_q <= 16'h0000;
            if (!nx_ph) begin
              tx_crc_q <= crc_step(tx_crc_q, nx_val);
            end
          end else begin
            tx_cnt_q <= 16'(tx_cnt_q + 16'h0001);
          end
        end
        TX_EOD: begin
          if (tx_cnt_q == 16'(EOD_CYC - 16'h0001)) begin
            tx_st_q <= TX_IDLE;
          end else begin
            tx_cnt_q <= 16'(tx_cnt_q + 16'h0001);
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  assign tx_o = tx_o_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_act_q <= 16'h0000;
    end else begin
      tx_act_q <= tx_o_q ? 16'(tx_act_q + 16'h0001) : 16'h0000;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_no_break_tx: assert property (tx_act_q < BRK_CYC)
    else $error("transmitter held active for a break length");
  a_break_tx_stop: assert property (tx_brk |=> !tx_o_q && tx_st_q == TX_IDLE && f_txe_q)
    else $error("break did not stop the transmitter");
  a_break_rx_drop: assert property (brk_pulse && in_frame_q |=> f_inv_q && !in_frame_q)
    else $error("break during reception not flagged");
  a_break_fast_clr: assert property (brk_pulse && in_frame_q && fast_q |=> !fast_q)
    else $error("fast receive enable survived a break");
  a_crc_err_flag: assert property (frame_end && rx_bc_q == 3'd0 && rx_crc_q != CRC_GOOD
                                   |=> f_crc_q)
    else $error("bad remainder did not set checksum error");
  a_crc_preset: assert property (rx_sof && !brk_pulse |=> rx_crc_q == CRC_INIT &&
                                 rx_cnt_q == 4'h0)
    else $error("start symbol did not preset checksum");
  a_eof_flag_set: assert property (eof_pulse |=> f_eof_q)
    else $error("end-of-frame flag not set");
  a_start_gap: assert property (tx_st_q == TX_WAIT && !start_ok |=> !tx_o_q)
    else $error("transmission began before separation expired");
  a_resync_edge: assert property (tx_st_q == TX_WAIT && rx_rise && per_q >= EOF_CYC && !tx_brk
                                  |=> tx_o_q && tx_cnt_q == 16'h0000)
    else $error("no resync to edge during separation");
  a_first_bit_pass: assert property (tx_st_q == TX_BIT && tx_bit_q == 3'd7 |-> !tx_o_q)
    else $error("byte began at active level");
  a_bit_length: assert property (tx_st_q == TX_BIT |->
                                 tx_dur_q == ((tx_cur_val ^ tx_o_q) ? LONG_CYC : SHORT_CYC))
    else $error("bit length does not match level and value");
  a_level_toggle: assert property (tx_st_q == TX_BIT && bit_end && !tx_last && !tx_brk
                                   |=> tx_o_q != $past(tx_o_q))
    else $error("consecutive bits share a level");
  a_sof_length: assert property ($rose(tx_o_q) && tx_st_q == TX_SOF |->
                                 tx_o_q [*8])
    else $error("start symbol cut short");

endmodule

// *** vpw_pkg.sv ***
package vpw_pkg;

  // ---------------------------------------------------------------
  // Clock and symbol timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SOF_US = 200;
  localparam int EOD_US = 200;
  localparam int EOF_US = 280;
  localparam int IFS_US = 300;
  localparam int SHORT_US = 64;
  localparam int LONG_US = 128;
  localparam int BRK_US = 240;
  // Receive decision points between nominal lengths
  localparam int MIN_US = 32;
  localparam int BIT_US = 96;
  localparam int SYM_US = 164;

  // ---------------------------------------------------------------
  // Frame and checksum
  // ---------------------------------------------------------------
  localparam logic [3:0] MAX_BYTES = 4'hC;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_GOOD = 8'hC4;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] LINK_CONTROL_TWO_OFS = 8'h00;
  localparam logic [7:0] TX_DATA_OFS = 8'h04;
  localparam logic [7:0] STATUS_VECTOR_REGISTER_OFS = 8'h08;
  localparam logic [7:0] RX_DATA_OFS = 8'h0C;

  localparam int CTL_GO_BIT = 0;
  localparam int CTL_FAST_BIT = 1;
  localparam int CTL_FLUSH_BIT = 2;

  localparam int ST_CRC_ERR = 0;
  localparam int ST_INV_SYM = 1;
  localparam int ST_EOF = 2;
  localparam int ST_RX_BYTE = 3;
  localparam int ST_TX_ERR = 4;
  localparam int ST_TX_BUSY = 5;
  localparam int ST_IDLE = 6;
  localparam int ST_IN_FRAME = 7;
  localparam int ST_RX_CNT_LO = 8;
  localparam int ST_TX_LEN_LO = 12;

  localparam logic [15:0] PER_MAX = 16'hFFFF;

  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_SOF, TX_BIT, TX_EOD} tx_state_t;

endpackage
